// *** src/rx_sync_out_pkg.sv ***
package rx_sync_out_pkg;

  // operating modes of the receive side
  typedef enum logic [1:0] {
    MODE_T1,
    MODE_E1,
    MODE_CC,
    MODE_6312
  } mode_t;

  // control word, as it sits in the control register
  typedef struct packed {
    logic  cc_cc_out_a_en;
    logic  signaling_double_pulse_en;
    logic  multiframe_pulse_select;
    logic  tx_clock_loss_indicator_select;
    logic  [1:0] spare;
    mode_t mode;
  } ctrl_t;

  // per-cycle indications from the framer and clock extractor, on the receive clock
  typedef struct packed {
    logic data;
    logic frame_bnd;
    logic multiframe_bnd;
    logic signaling_frame;
    logic sync_searching;
    logic cc_8k;
    logic cc_cc_out_a;
    logic cc_error;
  } rx_in_t;

  // register bus
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          ST_LOS_BIT    = 0;
  localparam int          ST_LOF_BIT    = 1;
  localparam int          ST_TXLOSS_BIT = 2;

  // loss-of-signal thresholds in received zeros
  localparam logic [7:0]  LOS_T1_ZEROS  = 8'hc0;
  localparam logic [7:0]  LOS_E1_ZEROS  = 8'hff;
  localparam int          LOS_CC_TIME_US     = 120;
  localparam int          CC_RX_CLK_KHZ      = 64;
  // least time: round up to whole receive clock periods
  localparam int          LOS_CC_CYCLES_INT  = (LOS_CC_TIME_US * CC_RX_CLK_KHZ + 999) / 1000;
  localparam logic [7:0]  LOS_CC_ZEROS       = LOS_CC_CYCLES_INT[7:0];
  localparam logic [7:0]  ZERO_CNT_MAX       = 8'hff;

  // transmit clock watchdog, in master clock periods
  localparam logic [3:0]  TXCLK_LOSS_PERIODS = 4'hf;

endpackage : rx_sync_out_pkg

// *** src/rx_sync_out.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - T1/E1 boundary output pulses one receive clock, frame or multiframe by select bit.
// - in T1 frame mode, optional two-clock pulse on signaling frames.
// - composite-clock mode puts the extracted 8kHz component on the boundary output.
// - composite-clock mode drives the cc_out_a output only when enabled.
// - T1/E1 modes float the cc_out_a output.
// - 6312kHz mode floats boundary, cc_out_a, serial data and frame-loss outputs.
// - T1/E1 serial data is NRZ, updated on each receive clock rising edge.
// - composite-clock mode floats the serial data output.
// - T1/E1 frame-loss output selects frame loss or transmit clock loss.
// - frame-loss reporting asserts while the synchronizer searches for alignment.
// - transmit-clock loss asserts after 16 master periods without a detected transition.
// - composite-clock mode raises frame-loss output on 8kHz or cc_out_a clock errors.
// - T1 loss of signal rises after 192 consecutive zeros.
// - E1 loss of signal rises after 255 consecutive zeros.
// - composite-clock loss of signal rises after at least 120us of zeros.
module rx_sync_out (
  input  wire  logic                          i_mclk,
  input  wire  logic                          i_srst,
  input  wire  logic                          i_rx_clk,
  input  wire  logic [rx_sync_out_pkg::ADDR_W-1:0] i_addr,
  input  wire  logic [rx_sync_out_pkg::DATA_W-1:0] i_wdata,
  input  wire  logic                          i_wr,
  input  wire  logic                          i_rd,
  output logic [rx_sync_out_pkg::DATA_W-1:0]      o_rdata,
  input  wire  logic                          i_tx_clock_in,
  input  wire  rx_sync_out_pkg::rx_in_t       i_rx_in,
  output logic                                o_rx_boundary_pulse,
  output logic                                o_rx_boundary_pulse_oe_n,
  output logic                                o_cc_out_a,
  output logic                                o_cc_out_a_oe_n,
  output logic                                o_rx_serial_data,
  output logic                                o_rx_serial_data_oe_n,
  output logic                                o_rx_frame_loss_or_cc_error,
  output logic                                o_rx_frame_loss_or_cc_error_oe_n,
  output logic                                o_rx_loss_of_signal
);
  import rx_sync_out_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // master clock side: registers and transmit clock watchdog

  ctrl_t             ctrl_q;
  logic              tx_meta_q;
  logic              tx_sync_q;
  logic              tx_last_q;
  logic [3:0]        tx_idle_q;
  logic              tx_lost_q;
  logic [1:0]        st_meta_q;
  logic [1:0]        st_sync_q;
  logic [DATA_W-1:0] rdata_q;
  logic              tx_edge;

  // control register write; low byte only, upper bits ignored
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
    end else if (i_wr && i_addr == CTRL_OFFSET) begin
      ctrl_q <= ctrl_t'(i_wdata[7:0]);
    end
  end

  // read data stands for exactly one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      rdata_q <= '0;
      if (i_addr == CTRL_OFFSET) begin
        rdata_q[7:0] <= ctrl_q;
      end else if (i_addr == STATUS_OFFSET) begin
        rdata_q[ST_LOS_BIT]    <= st_sync_q[0];
        rdata_q[ST_LOF_BIT]    <= st_sync_q[1];
        rdata_q[ST_TXLOSS_BIT] <= tx_lost_q;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_rdata = rdata_q;

  // the transmit clock is a foreign pin: two flops before any edge detection
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_meta_q <= 1'b0;
      tx_sync_q <= 1'b0;
      tx_last_q <= 1'b0;
    end else begin
      tx_meta_q <= i_tx_clock_in;
      tx_sync_q <= tx_meta_q;
      tx_last_q <= tx_sync_q;
    end
  end

  assign tx_edge = tx_sync_q ^ tx_last_q;

  // idle counter saturates so a dead clock keeps the alarm up indefinitely
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_idle_q <= '0;
      tx_lost_q <= 1'b0;
    end else if (tx_edge) begin
      tx_idle_q <= '0;
      tx_lost_q <= 1'b0;
    end else if (tx_idle_q == TXCLK_LOSS_PERIODS) begin
      tx_lost_q <= 1'b1;
    end else begin
      tx_idle_q <= tx_idle_q + 4'h1;
    end
  end

  // alarm levels back from the receive domain
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_meta_q <= '0;
      st_sync_q <= '0;
    end else begin
      st_meta_q <= {o_rx_frame_loss_or_cc_error, o_rx_loss_of_signal};
      st_sync_q <= st_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive clock side

  logic       rx_rst_meta_q;
  logic       rx_rst_q;
  ctrl_t      ctrl_meta_q;
  ctrl_t      ctrl_rx_q;
  logic       txl_meta_q;
  logic       txl_rx_q;
  logic       bnd_q;
  logic       bnd_oe_n_q;
  logic       bnd_hold_q;
  logic       a_q;
  logic       a_oe_n_q;
  logic       ser_q;
  logic       ser_oe_n_q;
  logic       lof_q;
  logic       lof_oe_n_q;
  logic       los_q;
  logic [7:0] zero_cnt_q;
  logic [7:0] zero_cnt_d;
  logic [7:0] los_thr;
  logic       is_t1e1;
  logic       bnd_sel;
  logic       dbl_start;

  // reset crossing into the receive domain; asserts and releases on receive edges
  always_ff @(posedge i_rx_clk) begin
    rx_rst_meta_q <= i_srst;
    rx_rst_q      <= rx_rst_meta_q;
  end

  // control is static in use, so a per-bit two-flop crossing is enough;
  // a change mid-operation may show a mixed word for one receive cycle
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q) begin
      ctrl_meta_q <= ctrl_t'(CTRL_RESET);
      ctrl_rx_q   <= ctrl_t'(CTRL_RESET);
    end else begin
      ctrl_meta_q <= ctrl_q;
      ctrl_rx_q   <= ctrl_meta_q;
    end
  end

  // transmit clock alarm level into the receive domain
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q) begin
      txl_meta_q <= 1'b0;
      txl_rx_q   <= 1'b0;
    end else begin
      txl_meta_q <= tx_lost_q;
      txl_rx_q   <= txl_meta_q;
    end
  end

  // boundary source and double-wide trigger
  assign is_t1e1   = (ctrl_rx_q.mode == MODE_T1) || (ctrl_rx_q.mode == MODE_E1);
  assign bnd_sel   = ctrl_rx_q.multiframe_pulse_select ? i_rx_in.multiframe_bnd : i_rx_in.frame_bnd;
  assign dbl_start = (ctrl_rx_q.mode == MODE_T1) && !ctrl_rx_q.multiframe_pulse_select &&
                     ctrl_rx_q.signaling_double_pulse_en && i_rx_in.frame_bnd && i_rx_in.signaling_frame;

  // boundary pulse output
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q) begin
      bnd_q      <= 1'b0;
      bnd_oe_n_q <= 1'b1;
      bnd_hold_q <= 1'b0;
    end else begin
      unique case (ctrl_rx_q.mode)
        MODE_T1, MODE_E1: begin
          bnd_q      <= bnd_sel | bnd_hold_q;
          bnd_oe_n_q <= 1'b0;
          bnd_hold_q <= dbl_start;
        end
        MODE_CC: begin
          bnd_q      <= i_rx_in.cc_8k;
          bnd_oe_n_q <= 1'b0;
          bnd_hold_q <= 1'b0;
        end
        MODE_6312: begin
          bnd_q      <= 1'b0;
          bnd_oe_n_q <= 1'b1;
          bnd_hold_q <= 1'b0;
        end
      endcase
    end
  end

  // cc_out_a output, driven only in composite-clock mode with the enable set
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q) begin
      a_q      <= 1'b0;
      a_oe_n_q <= 1'b1;
    end else if (ctrl_rx_q.mode == MODE_CC && ctrl_rx_q.cc_cc_out_a_en) begin
      a_q      <= i_rx_in.cc_cc_out_a;
      a_oe_n_q <= 1'b0;
    end else begin
      a_q      <= 1'b0;
      a_oe_n_q <= 1'b1;
    end
  end

  // serial data: one receive clock of latency, NRZ
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q) begin
      ser_q      <= 1'b0;
      ser_oe_n_q <= 1'b1;
    end else if (is_t1e1) begin
      ser_q      <= i_rx_in.data;
      ser_oe_n_q <= 1'b0;
    end else begin
      ser_q      <= 1'b0;
      ser_oe_n_q <= 1'b1;
    end
  end

  // frame loss / clock error / transmit clock loss
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q) begin
      lof_q      <= 1'b0;
      lof_oe_n_q <= 1'b1;
    end else begin
      unique case (ctrl_rx_q.mode)
        MODE_T1, MODE_E1: begin
          lof_q      <= ctrl_rx_q.tx_clock_loss_indicator_select ? txl_rx_q
                                                                 : i_rx_in.sync_searching;
          lof_oe_n_q <= 1'b0;
        end
        MODE_CC: begin
          lof_q      <= i_rx_in.cc_error;
          lof_oe_n_q <= 1'b0;
        end
        MODE_6312: begin
          lof_q      <= 1'b0;
          lof_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // zero-run threshold per mode
  always_comb begin
    unique case (ctrl_rx_q.mode)
      MODE_T1:   los_thr = LOS_T1_ZEROS;
      MODE_E1:   los_thr = LOS_E1_ZEROS;
      MODE_CC:   los_thr = LOS_CC_ZEROS;
      MODE_6312: los_thr = ZERO_CNT_MAX;
    endcase
  end

  // counter saturates, so an endless zero run never wraps and drops the alarm
  assign zero_cnt_d = (zero_cnt_q == ZERO_CNT_MAX) ? ZERO_CNT_MAX : zero_cnt_q + 8'h01;

  // loss of signal; not monitored in 6312kHz mode
  always_ff @(posedge i_rx_clk) begin
    if (rx_rst_q || ctrl_rx_q.mode == MODE_6312) begin
      zero_cnt_q <= '0;
      los_q      <= 1'b0;
    end else if (i_rx_in.data) begin
      zero_cnt_q <= '0;
      los_q      <= 1'b0;
    end else begin
      zero_cnt_q <= zero_cnt_d;
      if (zero_cnt_d >= los_thr) begin
        los_q <= 1'b1;
      end
    end
  end

  // pin outputs
  assign o_rx_boundary_pulse              = bnd_q;
  assign o_rx_boundary_pulse_oe_n         = bnd_oe_n_q;
  assign o_cc_out_a                       = a_q;
  assign o_cc_out_a_oe_n                  = a_oe_n_q;
  assign o_rx_serial_data                 = ser_q;
  assign o_rx_serial_data_oe_n            = ser_oe_n_q;
  assign o_rx_frame_loss_or_cc_error      = lof_q;
  assign o_rx_frame_loss_or_cc_error_oe_n = lof_oe_n_q;
  assign o_rx_loss_of_signal              = los_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  AST_BND_SINGLE: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (is_t1e1 && !dbl_start && !bnd_hold_q) |=> (o_rx_boundary_pulse == $past(bnd_sel)))
    else $error("boundary pulse does not follow selected boundary");

  AST_BND_DOUBLE: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (dbl_start && $stable(ctrl_rx_q)) |=> o_rx_boundary_pulse [*2])
    else $error("signaling frame pulse not two clocks wide");

  AST_BND_CC: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_CC) |=> (o_rx_boundary_pulse == $past(i_rx_in.cc_8k)) && !o_rx_boundary_pulse_oe_n)
    else $error("8kHz component missing on boundary output");

  AST_A_ENABLE: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_CC) |=> (o_cc_out_a_oe_n == !$past(ctrl_rx_q.cc_cc_out_a_en)))
    else $error("cc_out_a drive does not match enable");

  AST_A_T1E1_FLOAT: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    is_t1e1 |=> o_cc_out_a_oe_n)
    else $error("cc_out_a output driven in T1/E1 mode");

  AST_6312_FLOAT: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_6312) |=> (o_rx_boundary_pulse_oe_n && o_cc_out_a_oe_n &&
                                        o_rx_serial_data_oe_n && o_rx_frame_loss_or_cc_error_oe_n))
    else $error("output driven in 6312kHz mode");

  AST_SER_FOLLOW: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    is_t1e1 |=> (o_rx_serial_data == $past(i_rx_in.data)) && !o_rx_serial_data_oe_n)
    else $error("serial data not one receive clock behind input");

  AST_SER_CC_FLOAT: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_CC) |=> o_rx_serial_data_oe_n)
    else $error("serial data driven in composite-clock mode");

  AST_LOF_TXSEL: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (is_t1e1 && ctrl_rx_q.tx_clock_loss_indicator_select) |=> (o_rx_frame_loss_or_cc_error == $past(txl_rx_q)))
    else $error("transmit clock loss not reported when selected");

  AST_LOF_SEARCH: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (is_t1e1 && !ctrl_rx_q.tx_clock_loss_indicator_select) |=>
      (o_rx_frame_loss_or_cc_error == $past(i_rx_in.sync_searching)))
    else $error("frame loss does not follow synchronizer search");

  AST_TXLOSS_TIME: assert property (@(posedge i_mclk) disable iff (i_srst)
    (!tx_edge [*8] ##1 !tx_edge [*8]) |=> tx_lost_q)
    else $error("transmit clock loss not flagged after 16 idle cycles");

  AST_TXLOSS_CLEAR: assert property (@(posedge i_mclk) disable iff (i_srst)
    tx_edge |=> !tx_lost_q && (tx_idle_q == 4'h0))
    else $error("transmit clock loss not cleared by an edge");

  AST_LOF_CC: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_CC) |=> (o_rx_frame_loss_or_cc_error == $past(i_rx_in.cc_error)))
    else $error("composite clock error not reported");

  AST_LOS_RISE: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    ($rose(o_rx_loss_of_signal) && $stable(ctrl_rx_q)) |-> (zero_cnt_q == los_thr))
    else $error("loss of signal rose at wrong zero count");

  AST_LOS_CLEAR: assert property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    i_rx_in.data |=> !o_rx_loss_of_signal && (zero_cnt_q == 8'h00))
    else $error("received one did not clear loss of signal");

  COV_DOUBLE_PULSE: cover property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    dbl_start ##1 o_rx_boundary_pulse ##1 o_rx_boundary_pulse);

  COV_LOS_T1: cover property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_T1) && $rose(o_rx_loss_of_signal));

  COV_LOS_CC: cover property (@(posedge i_rx_clk) disable iff (rx_rst_q)
    (ctrl_rx_q.mode == MODE_CC) && $rose(o_rx_loss_of_signal));

  COV_TXLOSS: cover property (@(posedge i_mclk) disable iff (i_srst)
    $rose(tx_lost_q));

endmodule : rx_sync_out

`default_nettype wire

// *** test/rx_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// upstream framer and clock extractor: eight-bit frames, four-frame multiframe
module rx_line_model
  import rx_sync_out_pkg::*;
(
  input  wire logic                    i_rx_clk,
  input  wire logic                    i_quiet,
  output var  rx_sync_out_pkg::rx_in_t o_rx_in
);
  logic [2:0] pos_q   = 3'h0;
  logic [1:0] frm_q   = 2'h0;
  logic       quiet_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // free running position, like a recovered line that never stops
  always @(posedge i_rx_clk) begin
    pos_q   <= pos_q + 3'h1;
    quiet_q <= i_quiet;
    if (pos_q == 3'h7) begin
      frm_q <= frm_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indications follow the position; a quiet line sends nothing but zeros
  always_comb begin
    o_rx_in.data            = ~quiet_q & (pos_q[1:0] != 2'h1); // at most one zero in a row unless quiet
    o_rx_in.frame_bnd       = (pos_q == 3'h0);
    o_rx_in.multiframe_bnd  = (pos_q == 3'h0) && (frm_q == 2'h0);
    o_rx_in.signaling_frame = (frm_q == 2'h2); // level over the whole frame
    o_rx_in.sync_searching  = frm_q[0];
    o_rx_in.cc_8k           = pos_q[2];
    o_rx_in.cc_cc_out_a        = frm_q[1];
    o_rx_in.cc_error        = (frm_q == 2'h3) && pos_q[1];
  end
endmodule : rx_line_model

`default_nettype wire

// *** test/receive_sync_status_outputs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module receive_sync_status_outputs_tb_top;
  import rx_sync_out_pkg::*;

  localparam int TIMEOUT_CYCLES = 20000;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] oe;
  } row_t;
  // oe order: boundary, cc_out_a, serial data, frame loss
  localparam row_t ROWS [11] = '{'{8'h00, 4'h4}, '{8'h01, 4'h4}, '{8'h20, 4'h4}, '{8'h40, 4'h4},
    '{8'h41, 4'h4}, '{8'h90, 4'h4}, '{8'h0c, 4'h4}, '{8'h02, 4'h6}, '{8'h82, 4'h2}, '{8'h03, 4'hf},
    '{8'h83, 4'hf}};

  logic        i_mclk = 1'b0, i_srst = 1'b1, i_rx_clk = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_tx_clock_in = 1'b0;
  logic        tx_run = 1'b1, quiet = 1'b0, chk_on = 1'b0, lof_skip = 1'b0;
  logic [3:0]  i_addr = 4'h0, exp_oe = 4'hf;
  logic [7:0]  ctrl_w = 8'h00, zc_m = 8'h00, thr_m;
  logic [31:0] i_wdata = 32'h0, rd, o_rdata;
  mode_t       mode_m;
  rx_in_t      rx_in, seen_q, seen_prev_q;
  logic        o_bnd, o_bnd_oe_n, o_cc, o_cc_oe_n, o_ser, o_ser_oe_n, o_lof, o_lof_oe_n, o_los;
  int          n_fail = 0, compares = 0, cycles = 0;

  always #20 i_mclk = ~i_mclk;
  // receive clock offset so its edges never meet the master clock edges
  initial begin
    #13;
    forever #80 i_rx_clk = ~i_rx_clk;
  end
  always @(posedge i_mclk) if (tx_run) i_tx_clock_in <= ~i_tx_clock_in;

  rx_sync_out DUT (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_rx_clk(i_rx_clk), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_clock_in(i_tx_clock_in), .i_rx_in(rx_in),
    .o_rx_boundary_pulse(o_bnd), .o_rx_boundary_pulse_oe_n(o_bnd_oe_n), .o_cc_out_a(o_cc),
    .o_cc_out_a_oe_n(o_cc_oe_n), .o_rx_serial_data(o_ser), .o_rx_serial_data_oe_n(o_ser_oe_n),
    .o_rx_frame_loss_or_cc_error(o_lof), .o_rx_frame_loss_or_cc_error_oe_n(o_lof_oe_n),
    .o_rx_loss_of_signal(o_los));

  rx_line_model u_line (.i_rx_clk(i_rx_clk), .i_quiet(quiet), .o_rx_in(rx_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe edge
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : reg_rd

  // held longer than three cycles: the receive side needs several of its own edges
  task automatic do_reset();
    chk_on = 1'b0;
    @(posedge i_mclk);
    i_srst <= 1'b1;
    repeat (20) @(posedge i_mclk);
    #1;
    check({o_bnd_oe_n, o_cc_oe_n, o_ser_oe_n, o_lof_oe_n, o_los}, 5'h1e, "reset pins");
    @(posedge i_mclk);
    i_srst <= 1'b0;
    reg_rd(CTRL_OFFSET, rd);
    check(rd, 32'h0, "ctrl reset");
  endtask : do_reset

  task automatic rx_wait(input int n);
    repeat (n) @(posedge i_rx_clk);
  endtask : rx_wait

  // control needs three receive edges to act, so checks pause meanwhile
  task automatic set_mode(input logic [7:0] c, input logic [3:0] oe);
    chk_on = 1'b0;
    ctrl_w = c;
    exp_oe = oe;
    reg_wr(CTRL_OFFSET, {24'h0, c});
    rx_wait(8);
    chk_on = 1'b1;
  endtask : set_mode

  task automatic wait_lof(input logic lvl, input int lim);
    int n;
    n = 0;
    while (o_lof !== lvl && n < lim) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    check(o_lof, lvl, "tx clock loss level");
  endtask : wait_lof

  ////////////////////////////////////////////////////////////////////////////
  // the sample the design took at this edge, and the one before it
  always @(posedge i_rx_clk) begin
    seen_prev_q <= seen_q;
    seen_q      <= rx_in;
  end

  // pin model: each output follows the sample of the last receive edge; the signaling-frame boundary pulse also uses the one before it
  always @(negedge i_rx_clk) begin
    zc_m = seen_q.data ? 8'h00 : ((zc_m == ZERO_CNT_MAX) ? zc_m : zc_m + 8'h01);
    if (i_srst) zc_m = 8'h00;
    mode_m = mode_t'(ctrl_w[1:0]);
    thr_m = (mode_m == MODE_T1) ? LOS_T1_ZEROS : ((mode_m == MODE_E1) ? LOS_E1_ZEROS : LOS_CC_ZEROS);
    if (chk_on) begin
      check({o_bnd_oe_n, o_cc_oe_n, o_ser_oe_n, o_lof_oe_n}, exp_oe, "enables");
      if (mode_m == MODE_CC) begin
        check(o_bnd, seen_q.cc_8k, "8k component");
        check(o_cc, ctrl_w[7] & seen_q.cc_cc_out_a, "cc_out_a out");
        check(o_lof, seen_q.cc_error, "cc error");
      end else if (mode_m != MODE_6312) begin
        check(o_bnd, ctrl_w[5] ? seen_q.multiframe_bnd : (seen_q.frame_bnd | (ctrl_w[6] & (mode_m == MODE_T1)
          & seen_prev_q.frame_bnd & seen_prev_q.signaling_frame)), "boundary");
        check(o_ser, seen_q.data, "serial data");
        if (!lof_skip) check(o_lof, ctrl_w[4] ? 1'b0 : seen_q.sync_searching, "frame loss");
      end
      check(o_los, (mode_m != MODE_6312) && (zc_m >= thr_m), "loss of signal");
    end
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      n_fail++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    reg_wr(CTRL_OFFSET, 32'hffff_ff3c);
    reg_wr(4'h8, 32'h0000_0055);
    reg_wr(STATUS_OFFSET, 32'h0000_00aa);
    reg_rd(CTRL_OFFSET, rd);
    check(rd, 32'h3c, "ctrl low byte only");
    reg_rd(4'h8, rd);
    check(rd, 32'h0, "unmapped read");
    reg_rd(STATUS_OFFSET, rd);
    check(rd[ST_TXLOSS_BIT], 1'b0, "tx clock present");
    check(rd[31:3], 29'h0, "status read only");
    foreach (ROWS[i]) begin
      set_mode(ROWS[i].ctrl, ROWS[i].oe);
      rx_wait(40);
    end
    // long zero runs in each monitored mode, then a one to clear
    for (int k = 0; k < 3; k++) begin
      set_mode(8'(k), (k == 2) ? 4'h6 : 4'h4);
      quiet <= 1'b1;
      rx_wait(270);
      reg_rd(STATUS_OFFSET, rd);
      check(rd[ST_LOS_BIT], 1'b1, "status los");
      quiet <= 1'b0;
      rx_wait(8);
    end
    // stopped transmit clock: reported only when selected
    set_mode(8'h10, 4'h4);
    lof_skip = 1'b1;
    tx_run <= 1'b0;
    repeat (15) @(posedge i_mclk);
    #1;
    check(o_lof, 1'b0, "tx loss too early");
    wait_lof(1'b1, 80);
    reg_rd(STATUS_OFFSET, rd);
    check(rd[ST_TXLOSS_BIT:ST_LOF_BIT], 2'h3, "status tx loss");
    lof_skip = 1'b0;
    set_mode(8'h00, 4'h4);
    rx_wait(40);
    lof_skip = 1'b1;
    set_mode(8'h10, 4'h4);
    tx_run <= 1'b1;
    wait_lof(1'b0, 80);
    lof_skip = 1'b0;
    rx_wait(16);
    // second reset in mid-run: pins float, control falls back to its reset value
    do_reset();
    set_mode(8'h00, 4'h4);
    rx_wait(16);
    give_verdict();
  end
endmodule : receive_sync_status_outputs_tb_top

`default_nettype wire
